/* File: verilog/qa_watchdog_defines.svh */
/*
  Constants of the question-and-answer watchdog: reset values, limits and timing counts.
  Assumes a 200 MHz core clock; included by the watchdog module only.
*/
`ifndef QA_WATCHDOG_DEFINES_SVH
`define QA_WATCHDOG_DEFINES_SVH

// ==========================================================
// timing
`define QA_CLK_NS 5
`define QA_MS_NS 1000000
`define QA_MS_CYCLES (`QA_MS_NS / `QA_CLK_NS)
`define QA_WINDOW_MS 8
`define QA_RST_PULSE_CYCLES 16

// ==========================================================
// counter values
`define QA_EC_RESET 3'h6
`define QA_EC_ALARM 3'h4
`define QA_CNT_MAX 3'h7
`define QA_BYTE_FIRST 2'h3
`define QA_DELAY_RESET 8'h00
`define QA_NIBBLE_ZERO 4'h0
`define QA_NIBBLE_TOP 4'hF

`endif

/* File: verilog/qa_watchdog_pkg.sv */
/*
  Types shared by the question-and-answer watchdog.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package qa_watchdog_pkg;
  // ==========================================================
  // monitoring cycle phase
  typedef enum logic {
    PH_WAIT,
    PH_WINDOW
  } phase_t;
endpackage : qa_watchdog_pkg

`default_nettype wire

/* File: verilog/question_answer_watchdog.sv */
/*
  Algorithmic question-and-answer watchdog: question generation, answer checking,
  timed monitoring cycle, error, reset-event and after-run abort counters.
  Assumes host strobes come from logic on clk_i; rstn_i is the undervoltage reset.
*/
`default_nettype none
`include "qa_watchdog_defines.svh"

// What this block does
// - the 4-bit question word is presented for the host to read
// - byte 0 write end or response-delay write starts a new cycle
// - a cycle is wait time then fixed window; window end restarts it
// - correct answer in window with nonzero delay decrements the error count
// - wrong, late, early or zero-delay answer increments the error count
// - only byte 0 completion is timed; earlier bytes may come anytime
// - question repeats until answered right in value and time
// - error count is 3 bits, starts at 6 after reset and overflow
// - error count above 4 raises alarm and disables output stages
// - overflow drives the reset pin only when watchdog resets are enabled
// - watchdog resets are counted; at 7 no more are generated
// - alarm pin is driven low whenever the reset pin shows a reset
// - overflow bumps abort count; at 7 a further overflow ends after-run
// - abort count clears only with alarm low or undervoltage reset
// - comparison result and next question are shown after byte 0
// - question counter steps only on a correct, timely answer
// - chain steps on counter wrap 15 to 0, only after a correct answer
// - delay write or window expiry leaves counter and chain alone
// - counter and chain are zero while undervoltage reset is active
// - chain feedback is bit3 xor bit2, plus an escape from all zero
// - question bits mix chain and counter bits in the fixed pattern
// - internal alarm is high whenever error count exceeds 4
// - with resets disabled the watchdog never drives the reset pin
module question_answer_watchdog
  import qa_watchdog_pkg::*;
#(
  parameter int MS_CYCLES = `QA_MS_CYCLES,
  parameter int WINDOW_MS = `QA_WINDOW_MS,
  parameter int RST_PULSE_CYCLES = `QA_RST_PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic answer_write_i,
  input wire logic [7:0] answer_byte_i,
  input wire logic response_delay_write_i,
  input wire logic [7:0] response_delay_i,
  input wire logic watchdog_reset_enable_i,
  input wire logic reset_pin_i,
  input wire logic alarm_pin_i,
  output logic [3:0] question_word_o,
  output logic answer_error_o,
  output logic [2:0] error_count_o,
  output logic [2:0] reset_event_count_o,
  output logic [2:0] afterrun_abort_count_o,
  output logic afterrun_abort_o,
  output logic alarm_internal_o,
  output logic stage_disable_o,
  output logic alarm_pin_out_o,
  output logic alarm_pin_oe_o,
  output logic reset_pin_out_o,
  output logic reset_pin_oe_o
);
  localparam int PRE_W = $clog2(MS_CYCLES);
  localparam int RP_W = $clog2(RST_PULSE_CYCLES + 1);

  // ==========================================================
  // state
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    phase_t phase;
    logic [7:0] timer;
    logic [7:0] delay;
    logic [1:0] resp_cnt;
    logic resp_err;
    logic result;
    logic [3:0] qcnt;
    logic [3:0] chain;
    logic [3:0] question;
    logic [2:0] ec;
    logic [2:0] reset_event_count;
    logic [2:0] afterrun_abort_count;
    logic abort;
    logic alarm;
    logic [RP_W-1:0] rst_timer;
    logic rst_drive;
    logic alarm_oe;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_low;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic run_good;
  logic run_err;
  logic run_any;
  logic overflow;

  // expected answer byte for a question and byte position
  function automatic logic [7:0] expect_byte(input logic [3:0] q, input logic [1:0] c);
    expect_byte = {q[2] ^ c[0], q[0] ^ c[0], q[3] ^ c[0], q[1] ^ c[0],
                   q[2] ^ q[0] ^ q[3] ^ c[1], q[0] ^ q[3] ^ q[1] ^ c[1],
                   q[2] ^ q[0] ^ q[1] ^ c[1], c[1] ^ q[3] ^ q[0]};
  endfunction : expect_byte

  function automatic logic [3:0] make_question(input logic [3:0] m, input logic [3:0] z);
    make_question = {m[2] ^ z[2], m[0] ^ z[0], m[3] ^ z[3], m[1] ^ z[1]};
  endfunction : make_question

  // ==========================================================
  // next state
  always_comb begin
    logic ms_tick;
    logic byte_ok;
    logic run_ans;
    logic run_time;
    ms_tick = 1'b0;
    byte_ok = 1'b0;
    run_ans = 1'b0;
    run_time = 1'b0;
    s_nxt = s_r;
    run_good = 1'b0;
    run_err = 1'b0;
    overflow = 1'b0;
    // pin level counts once the second and third stage agree
    s_nxt.pin_s1 = reset_pin_i;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_s3 = s_r.pin_s2;
    if (s_r.pin_s2 == s_r.pin_s3) begin
      s_nxt.pin_low = !s_r.pin_s3;
    end
    // free-running prescaler: wait and window are exact to one ms only
    ms_tick = (s_r.pre == PRE_W'(MS_CYCLES - 1));
    s_nxt.pre = ms_tick ? '0 : s_r.pre + PRE_W'(1);
    byte_ok = (answer_byte_i == expect_byte(s_r.question, s_r.resp_cnt));
    run_ans = answer_write_i && (s_r.resp_cnt == 2'h0);
    run_time = ms_tick && (s_r.phase == PH_WINDOW) && (s_r.timer == 8'h00);
    if (answer_write_i) begin
      s_nxt.resp_cnt = s_r.resp_cnt - 2'h1;
      s_nxt.resp_err = s_r.resp_err | !byte_ok;
    end
    run_good = run_ans && !s_r.resp_err && byte_ok && (s_r.phase == PH_WINDOW)
               && (s_r.delay != 8'h00);
    run_err = (run_ans && !run_good) || (run_time && !run_ans);
    run_any = run_ans || run_time || response_delay_write_i;
    if (response_delay_write_i) begin
      s_nxt.delay = response_delay_i;
    end
    if (run_any) begin
      // restart the cycle: wait time first, then the window
      s_nxt.phase = PH_WAIT;
      s_nxt.timer = response_delay_write_i ? response_delay_i : s_r.delay;
      s_nxt.resp_cnt = `QA_BYTE_FIRST;
      s_nxt.resp_err = 1'b0;
    end else if (ms_tick) begin
      if (s_r.timer != 8'h00) begin
        s_nxt.timer = s_r.timer - 8'h01;
      end else if (s_r.phase == PH_WAIT) begin
        s_nxt.phase = PH_WINDOW;
        s_nxt.timer = 8'(WINDOW_MS - 1);
      end
    end
    if (run_ans) begin
      s_nxt.result = !run_good;
    end
    // questions move on only after a correct, timely answer
    if (run_good) begin
      s_nxt.qcnt = s_r.qcnt + 4'h1;
      if (s_r.qcnt == `QA_NIBBLE_TOP) begin
        s_nxt.chain = {s_r.chain[2:0], s_r.chain[3] ^ s_r.chain[2]
                       ^ (s_r.chain == `QA_NIBBLE_ZERO)};
      end
      if (s_r.ec != 3'h0) begin
        s_nxt.ec = s_r.ec - 3'h1;
      end
    end
    s_nxt.question = make_question(s_nxt.chain, s_nxt.qcnt);
    if (run_err) begin
      if (s_r.ec == `QA_CNT_MAX) begin
        overflow = 1'b1;
        s_nxt.ec = `QA_EC_RESET;
      end else begin
        s_nxt.ec = s_r.ec + 3'h1;
      end
    end
    if (overflow) begin
      // reset generation stops for good once seven have been issued
      if (watchdog_reset_enable_i && (s_r.reset_event_count != `QA_CNT_MAX)) begin
        s_nxt.reset_event_count = s_r.reset_event_count + 3'h1;
        s_nxt.rst_timer = RP_W'(RST_PULSE_CYCLES);
      end
      if (s_r.afterrun_abort_count == `QA_CNT_MAX) begin
        s_nxt.abort = 1'b1;
      end else begin
        s_nxt.afterrun_abort_count = s_r.afterrun_abort_count + 3'h1;
      end
    end else if (s_r.rst_timer != '0) begin
      s_nxt.rst_timer = s_r.rst_timer - RP_W'(1);
    end
    s_nxt.alarm = (s_nxt.ec > `QA_EC_ALARM);
    if (!s_nxt.alarm) begin
      s_nxt.afterrun_abort_count = 3'h0;
      s_nxt.abort = 1'b0;
    end
    s_nxt.rst_drive = (s_nxt.rst_timer != '0);
    s_nxt.alarm_oe = s_nxt.alarm | s_nxt.rst_drive | s_nxt.pin_low;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.phase <= PH_WAIT;
      s_r.delay <= `QA_DELAY_RESET;
      s_r.resp_cnt <= `QA_BYTE_FIRST;
      s_r.question <= `QA_NIBBLE_ZERO;
      s_r.ec <= `QA_EC_RESET;
      s_r.alarm <= 1'b1;
      s_r.alarm_oe <= 1'b1;
      s_r.pin_s1 <= 1'b1;
      s_r.pin_s2 <= 1'b1;
      s_r.pin_s3 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs; open-drain pins only ever pull low
  assign question_word_o = s_r.question;
  assign answer_error_o = s_r.result;
  assign error_count_o = s_r.ec;
  assign reset_event_count_o = s_r.reset_event_count;
  assign afterrun_abort_count_o = s_r.afterrun_abort_count;
  assign afterrun_abort_o = s_r.abort;
  assign alarm_internal_o = s_r.alarm;
  assign stage_disable_o = s_r.alarm;
  assign alarm_pin_out_o = 1'b0;
  assign alarm_pin_oe_o = s_r.alarm_oe;
  assign reset_pin_out_o = 1'b0;
  assign reset_pin_oe_o = s_r.rst_drive;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence byte0_seq;
    answer_write_i && (s_r.resp_cnt == 2'h0);
  endsequence

  sequence wait_seq;
    (s_r.phase == PH_WAIT) && (s_r.resp_cnt == `QA_BYTE_FIRST);
  endsequence

  alarm_level_a: assert property (s_r.alarm == (s_r.ec > `QA_EC_ALARM))
    else $error("alarm does not follow error count");
  stage_off_a: assert property (s_r.ec > `QA_EC_ALARM |-> stage_disable_o)
    else $error("stages not disabled in alarm");
  cycle_start_a: assert property (byte0_seq |=> wait_seq)
    else $error("byte 0 did not restart cycle");
  ec_down_a: assert property (run_good && s_r.ec != 3'h0 |=>
    s_r.ec == $past(s_r.ec) - 3'h1)
    else $error("error count not decremented");
  ec_up_a: assert property (run_err |=>
    s_r.ec == (($past(s_r.ec) == 3'h7) ? 3'h6 : $past(s_r.ec) + 3'h1))
    else $error("error count not incremented");
  q_hold_a: assert property (!run_good |=> $stable(question_word_o))
    else $error("question changed without correct answer");
  wdr_gate_a: assert property ($rose(reset_pin_oe_o) |->
    $past(watchdog_reset_enable_i) && $past(overflow))
    else $error("reset driven without enable and overflow");
  rst_cap_a: assert property (reset_event_count_o == 3'h7 |=>
    reset_event_count_o == 3'h7 && !$rose(reset_pin_oe_o))
    else $error("reset generated past count of seven");
  alarm_rst_a: assert property (reset_pin_oe_o |-> alarm_pin_oe_o)
    else $error("alarm pin not low during reset");
  abort_clr_a: assert property (!alarm_internal_o |->
    afterrun_abort_count_o == 3'h0 && !afterrun_abort_o)
    else $error("abort count kept with alarm low");
  chain_esc_a: assert property (run_good && s_r.qcnt == 4'hF && s_r.chain == 4'h0
    |=> s_r.chain == 4'h1)
    else $error("chain stuck at zero");
  // a delay write or an expiry must not step the question state
  q_step_a: assert property (!run_good |=> $stable(s_r.qcnt) && $stable(s_r.chain))
    else $error("question state moved without correct answer");
  // pin and after-run reactions
  rst_pulse_a: assert property ($rose(reset_pin_oe_o) |-> reset_pin_oe_o [*8])
    else $error("reset pulse too short");
  wdr_off_a: assert property (!watchdog_reset_enable_i |=> !$rose(reset_pin_oe_o))
    else $error("reset driven while resets disabled");
  pin_alarm_a: assert property (s_r.pin_low |-> alarm_pin_oe_o)
    else $error("alarm pin not low while reset pin low");
  abort_set_a: assert property (overflow && s_r.afterrun_abort_count == 3'h7 |=> afterrun_abort_o)
    else $error("after-run not terminated");
endmodule : question_answer_watchdog

`default_nettype wire

/* File: test/qa_host_model.sv */
/*
  Host model: fetches the question and writes answers and wait times.
  Assumes strobes are sampled on the rising clock edge; it drives on the falling one.
*/
`default_nettype none

module qa_host_model (
  input wire logic clk_i,
  input wire logic [3:0] question_word_i,
  output logic answer_write_o,
  output logic [7:0] answer_byte_o,
  output logic response_delay_write_o,
  output logic [7:0] response_delay_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // answer generation
  function automatic logic [7:0] expect_byte(input logic [3:0] q, input logic [1:0] n);
    logic c0;
    logic c1;
    c0 = n[0];
    c1 = n[1];
    return {q[2] ^ c0, q[0] ^ c0, q[3] ^ c0, q[1] ^ c0, q[2] ^ q[0] ^ q[3] ^ c1,
            q[0] ^ q[3] ^ q[1] ^ c1, q[2] ^ q[0] ^ q[1] ^ c1, c1 ^ q[3] ^ q[0]};
  endfunction : expect_byte

  initial begin
    answer_write_o = 1'b0;
    answer_byte_o = 8'h00;
    response_delay_write_o = 1'b0;
    response_delay_o = 8'h00;
  end

  // question is fetched once, so all four bytes answer the same one
  task automatic send_answer(input int lead, input logic [7:0] flip);
    logic [3:0] q;
    repeat (lead) @(negedge clk_i);
    q = question_word_i;
    for (int n = 3; n >= 0; n--) begin
      @(negedge clk_i);
      answer_write_o = 1'b1;
      answer_byte_o = expect_byte(q, 2'(n)) ^ ((n == 0) ? flip : 8'h00);
    end
    @(negedge clk_i);
    answer_write_o = 1'b0;
    answer_byte_o = ~answer_byte_o;
  endtask : send_answer

  task automatic write_delay(input logic [7:0] ms);
    @(negedge clk_i);
    response_delay_write_o = 1'b1;
    response_delay_o = ms;
    @(negedge clk_i);
    response_delay_write_o = 1'b0;
    response_delay_o = ~ms;
  endtask : write_delay
endmodule : qa_host_model

`default_nettype wire

/* File: test/tb_question_answer_watchdog.sv */
/*
  Self-checking bench of the question-and-answer watchdog.
  Assumes a shortened millisecond prescaler; pins are open drain with pull-ups.
*/
`default_nettype none

module tb_question_answer_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  // wait of 5 ms keeps quick answers clear of the window
  localparam int TIMELY = 5 * MS + 80;
  logic clk = 1'b0;
  logic rstn;
  logic wre;
  logic ext_rst;
  logic aw, dw, alarm, stg, abo, aerr, apoe, rpoe, rpin, apin;
  logic [7:0] ab, dv;
  logic [3:0] q;
  logic [2:0] ec, rc, abc;
  logic [3:0] z = 4'h0;
  logic [3:0] m = 4'h0;
  int n_mismatch = 0;
  int n_compared = 0;
  int len;

  always #2.5 clk = ~clk;
  assign rpin = ~(rpoe | ext_rst);
  assign apin = ~apoe;

  question_answer_watchdog #(.MS_CYCLES(MS)) question_answer_watchdog_i (
    .clk_i(clk), .rstn_i(rstn), .answer_write_i(aw), .answer_byte_i(ab),
    .response_delay_write_i(dw), .response_delay_i(dv), .watchdog_reset_enable_i(wre),
    .reset_pin_i(rpin), .alarm_pin_i(apin), .question_word_o(q), .answer_error_o(aerr),
    .error_count_o(ec), .reset_event_count_o(rc), .afterrun_abort_count_o(abc),
    .afterrun_abort_o(abo), .alarm_internal_o(alarm), .stage_disable_o(stg),
    .alarm_pin_out_o(), .alarm_pin_oe_o(apoe), .reset_pin_out_o(), .reset_pin_oe_o(rpoe));

  qa_host_model qa_host_model_i (.clk_i(clk), .question_word_i(q), .answer_write_o(aw),
    .answer_byte_o(ab), .response_delay_write_o(dw), .response_delay_o(dv));

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] qexp();
    return {4'h0, m[2] ^ z[2], m[0] ^ z[0], m[3] ^ z[3], m[1] ^ z[1]};
  endfunction : qexp

  task automatic advance();
    z = z + 4'h1;
    if (z == 4'h0) m = {m[2:0], (m[3] ^ m[2]) | (m == 4'h0)};
  endtask : advance

  task automatic ans(input int lead, input logic [7:0] flip);
    qa_host_model_i.send_answer(lead, flip);
    repeat (2) @(negedge clk);
  endtask : ans

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    #200us;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================
  // tests
  initial begin
    rstn = 1'b0;
    wre = 1'b0;
    ext_rst = 1'b0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(ec, 8'h06);
    chk(q, 8'h00);
    chk({alarm, stg, abc, rc}, 8'hC0);
    // inside the window, so only the zero wait time makes it wrong
    ans(2 * MS, 8'h00);
    chk(ec, 8'h07);
    chk(q, 8'h00);
    $display("test reset and zero delay done");
    qa_host_model_i.write_delay(8'h05);
    ans(TIMELY, 8'h00);
    advance();
    chk({aerr, ec}, 8'h06);
    chk(q, qexp());
    ans(0, 8'h00);
    chk(ec, 8'h07);
    chk(q, qexp());
    ans(TIMELY, 8'h01);
    chk({aerr, ec}, 8'h0E);
    chk({rpoe, abc, rc}, 8'h08);
    $display("test answer timing done");
    wre = 1'b1;
    for (int k = 1; k <= 8; k++) begin
      ans(0, 8'h00);
      qa_host_model_i.send_answer(0, 8'h00);
      // the pulse starts half a clock before the falling edge that ends the task, so count it from here
      len = int'(rpoe);
      repeat (39) @(negedge clk) len += int'(rpoe);
      chk(8'(len), (k <= 7) ? 8'h10 : 8'h00);
      chk(rc, 8'((k <= 7) ? k : 7));
      chk({abo, abc}, {4'h0, k >= 7, 3'((k >= 6) ? 7 : k + 1)});
    end
    $display("test overflow resets done");
    repeat (2) begin
      ans(TIMELY, 8'h00);
      advance();
    end
    chk(ec, 8'h04);
    chk({alarm, stg}, 8'h00);
    chk({abo, abc, rc}, 8'h07);
    ext_rst = 1'b1;
    repeat (8) @(negedge clk);
    chk(apoe, 8'h01);
    ext_rst = 1'b0;
    repeat (8) @(negedge clk);
    chk(apoe, 8'h00);
    repeat (300) @(negedge clk);
    chk(ec, 8'h05);
    qa_host_model_i.write_delay(8'h05);
    chk(q, qexp());
    $display("test clearing and expiry done");
    repeat (16) begin
      ans(TIMELY, 8'h00);
      advance();
      chk(q, qexp());
    end
    rstn = 1'b0;
    @(negedge clk);
    chk({ec, rc}, 8'h30);
    chk(q, 8'h00);
    $display("test question sequence and reset done");
    wrap_up();
  end
endmodule : tb_question_answer_watchdog

`default_nettype wire
